// [design/iqoh_pkg.sv]
package iqoh_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses on the APB side)
    // ------------------------------------------------------------------
    localparam int          APB_AW      = 8;
    localparam logic [7:0]  OFS_CMD     = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_REPLY   = 8'h08;
    localparam logic [7:0]  OFS_ERRCLR  = 8'h0C;

    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_ERR_BIT      = 1;
    localparam int ST_FMT_BIT      = 2;
    localparam int ST_OUT_BIT      = 3;
    localparam int ST_PEND_BIT     = 4;
    localparam int ST_CNT_LSB      = 8;
    localparam int REPLY_VALID_BIT = 8;
    localparam int ERRCLR_BIT      = 0;
    localparam int CMD_W           = 24;

    // ------------------------------------------------------------------
    // commands, reply kinds, states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_ENC     = 3'b000,
        OP_FMT     = 3'b001,
        OP_HIGH    = 3'b010,
        OP_LOW     = 3'b011,
        OP_PATTERN = 3'b100,
        OP_BUFSET  = 3'b101
    } iqoh_op_t;

    typedef struct packed {
        logic [7:0] param;
        logic [6:0] rsvHi;
        logic       hasParam;
        logic [4:0] rsvLo;
        logic [2:0] op;
    } iqoh_cmd_t;

    typedef enum logic [1:0] {
        K_ENC = 2'b00,
        K_FMT = 2'b01,
        K_PAT = 2'b10
    } iqoh_kind_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_NAME = 3'b001,
        S_CONV = 3'b010,
        S_BODY = 3'b011,
        S_END  = 3'b100
    } iqoh_state_t;

    // ------------------------------------------------------------------
    // characters and sizes
    // ------------------------------------------------------------------
    localparam logic [7:0] CH_H     = 8'h48;
    localparam logic [7:0] CH_D     = 8'h44;
    localparam logic [7:0] CH_L     = 8'h4C;
    localparam logic [7:0] CH_EQ    = 8'h3D;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_ONE   = 8'h31;
    localparam logic [7:0] CH_ALPHA = 8'h37;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [15:0] TAG_ENC = 16'h4945;
    localparam logic [15:0] TAG_FMT = 16'h4946;
    localparam logic [15:0] TAG_PAT = 16'h494F;

    localparam logic [7:0] OUT_NUM   = 8'h01;
    localparam logic [7:0] PAT_MAX   = 8'h01;
    localparam logic       LVL_OPEN  = 1'b1;
    localparam logic       FMT_HEX   = 1'b0;

    localparam int         MEM_AW    = 4;
    localparam int         CNT_W     = 5;
    localparam int         DEC_DIG   = 10;
    localparam int         BCD_W     = 40;
    localparam logic [3:0] NAME_LAST = 4'h2;
    localparam logic [3:0] HEX_LAST  = 4'h7;
    localparam logic [3:0] PAT_LAST  = 4'h7;
    localparam logic [3:0] DEC_LAST  = 4'hA;
    localparam logic [5:0] CONV_LAST = 6'h1F;

    function automatic logic [7:0] nibToChar(input logic [3:0] n);
        return (n < 4'hA) ? (CH_ZERO + {4'h0, n}) : (CH_ALPHA + {4'h0, n});
    endfunction

endpackage

// [design/iqoh_reply_mem.sv]
`timescale 1ns/1ps
module iqoh_reply_mem
(
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    input  wire logic                      we,
    input  wire logic [iqoh_pkg::MEM_AW-1:0] waddr,
    input  wire logic [7:0]                wdata,
    input  wire logic [iqoh_pkg::MEM_AW-1:0] raddr,
    output logic      [7:0]                rdata
);
    import iqoh_pkg::*;
    logic [7:0] mem [0:(1<<MEM_AW)-1];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // write-first bypass: a character pushed into an empty reply is readable next cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

// [design/iqoh_bin2dec.sv]
`timescale 1ns/1ps
module iqoh_bin2dec
(
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    input  wire logic                      start,
    input  wire logic [31:0]               magnitude,
    output logic                           done,
    output logic      [iqoh_pkg::BCD_W-1:0] bcd
);
    import iqoh_pkg::*;
    logic [31:0]      shift_r, shift_nxt;
    logic [BCD_W-1:0] bcd_r, bcd_nxt, adj;
    logic [5:0]       step_r, step_nxt;
    logic             busy_r, busy_nxt, done_r, done_nxt;

    // shift-and-add-3: one bit per cycle, 32 shift cycles, so a decimal reply waits 33 cycles in S_CONV
    genvar d;
    generate
        for (d = 0; d < DEC_DIG; d++) begin : g_adj
            assign adj[d*4 +: 4] = (bcd_r[d*4 +: 4] > 4'h4) ? bcd_r[d*4 +: 4] + 4'h3
                                                            : bcd_r[d*4 +: 4];
        end
    endgenerate

    always_comb begin
        shift_nxt = shift_r;
        bcd_nxt   = bcd_r;
        step_nxt  = step_r;
        busy_nxt  = busy_r;
        done_nxt  = 1'b0;
        if (start) begin
            shift_nxt = magnitude;
            bcd_nxt   = '0;
            step_nxt  = '0;
            busy_nxt  = 1'b1;
        end else if (busy_r) begin
            {bcd_nxt, shift_nxt} = {adj[BCD_W-2:0], shift_r, 1'b0};
            step_nxt = step_r + 6'h01;
            if (step_r == CONV_LAST) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_r <= '0;
            bcd_r   <= '0;
            step_r  <= '0;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            bcd_r   <= bcd_nxt;
            step_r  <= step_nxt;
            busy_r  <= busy_nxt;
            done_r  <= done_nxt;
        end
    end

    assign done = done_r;
    assign bcd  = bcd_r;
endmodule

// [design/iqoh_handler.sv]
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// - encoder query replies present count, eight hex
// - negative hex counts sent as two's complement
// - decimal format sends signed count, minus sign
// - format only affects readout replies, not outputs
// - hexadecimal is the default reply format
// - immediate commands act at once, ignoring buffer
// - format letter H/D sets; bare reads letter
// - output 1 high-now opens output, no reply
// - output 1 low-now closes output, no reply
// - buffered set-output waits for buffered motion
// - bare pattern returns 8-bit string, bit0 output
// - pattern parameter sets output; only 0, 1
// - zero closes the output, one opens it
// - pattern readback only ever 0 or 1
// - energized reads low, de-energized reads high
// - L means low, H means high
// - position readback is 32 bits, 8 hex
module iqoh_handler
(
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [iqoh_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [31:0]                 encCount,
    input  wire logic                        bufBusy,
    output logic                             outLevel
);
    import iqoh_pkg::*;
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    iqoh_state_t          state_r, state_nxt;
    iqoh_kind_t           kind_r, kind_nxt;
    logic [3:0]           idx_r, idx_nxt;
    logic [31:0]          value_r, value_nxt;
    logic [BCD_W-1:0]     dig_r, dig_nxt;
    logic                 neg_r, neg_nxt;
    logic                 decMode_r, decMode_nxt;
    logic                 started_r, started_nxt;
    logic                 fmtDec_r, fmtDec_nxt;
    logic                 outLevel_r, outLevel_nxt;
    logic                 soPending_r, soPending_nxt;
    logic                 soLevel_r, soLevel_nxt;
    logic                 err_r, err_nxt;
    logic [MEM_AW-1:0]    wrPtr_r, wrPtr_nxt;
    logic [MEM_AW-1:0]    rdPtr_r, rdPtr_nxt;
    logic [CNT_W-1:0]     cnt_r, cnt_nxt;
    logic [31:0]          prdata_r, prdata_nxt;

    logic                 apbSetup, apbAccess, wrCmd, rdPop, errClr, errSet, mapped;
    logic                 memWe, convStart, convDone;
    logic [7:0]           memWdata, memRdata;
    logic [BCD_W-1:0]     convBcd;
    logic [31:0]          magnitude;
    logic [15:0]          tag;
    iqoh_cmd_t            cmd;

    function automatic logic isAddr(input logic [APB_AW-1:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    assign magnitude = value_r[31] ? (32'h0 - value_r) : value_r;

    iqoh_bin2dec u_conv (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .start     (convStart),
        .magnitude (magnitude),
        .done      (convDone),
        .bcd       (convBcd)
    );

    iqoh_reply_mem u_mem (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .we       (memWe),
        .waddr    (wrPtr_r),
        .wdata    (memWdata),
        .raddr    (rdPtr_nxt),
        .rdata    (memRdata)
    );

    // ------------------------------------------------------------------
    // APB decode: zero-wait slave, read data captured in the setup cycle
    // ------------------------------------------------------------------
    assign apbSetup  = psel & ~penable;
    assign apbAccess = psel & penable;
    assign mapped    = isAddr(paddr, OFS_CMD) | isAddr(paddr, OFS_STATUS) |
                       isAddr(paddr, OFS_REPLY) | isAddr(paddr, OFS_ERRCLR);
    assign pready    = 1'b1;
    assign pslverr   = apbAccess & ~mapped;
    assign wrCmd     = apbAccess & pwrite & isAddr(paddr, OFS_CMD);
    assign errClr    = apbAccess & pwrite & isAddr(paddr, OFS_ERRCLR) & pwdata[ERRCLR_BIT];
    assign rdPop     = apbAccess & ~pwrite & isAddr(paddr, OFS_REPLY) & (cnt_r != '0);
    assign cmd       = iqoh_cmd_t'(pwdata[CMD_W-1:0]);
    assign prdata    = prdata_r;
    assign outLevel  = outLevel_r;

    always_comb begin
        prdata_nxt = prdata_r;
        if (apbSetup && !pwrite) begin
            prdata_nxt = 32'h0;
            if (isAddr(paddr, OFS_STATUS)) begin
                prdata_nxt[ST_BUSY_BIT]               = (state_r != S_IDLE);
                prdata_nxt[ST_ERR_BIT]                = err_r;
                prdata_nxt[ST_FMT_BIT]                = fmtDec_r;
                prdata_nxt[ST_OUT_BIT]                = outLevel_r;
                prdata_nxt[ST_PEND_BIT]               = soPending_r;
                prdata_nxt[ST_CNT_LSB +: CNT_W]       = cnt_r;
            end else if (isAddr(paddr, OFS_REPLY)) begin
                prdata_nxt[REPLY_VALID_BIT]           = (cnt_r != '0);
                prdata_nxt[7:0]                       = (cnt_r != '0) ? memRdata : 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // command execution and reply builder
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt     = state_r;
        kind_nxt      = kind_r;
        idx_nxt       = idx_r;
        value_nxt     = value_r;
        dig_nxt       = dig_r;
        neg_nxt       = neg_r;
        decMode_nxt   = decMode_r;
        started_nxt   = started_r;
        fmtDec_nxt    = fmtDec_r;
        outLevel_nxt  = outLevel_r;
        soPending_nxt = soPending_r;
        soLevel_nxt   = soLevel_r;
        wrPtr_nxt     = wrPtr_r;
        rdPtr_nxt     = rdPtr_r;
        cnt_nxt       = cnt_r;
        errSet        = 1'b0;
        memWe         = 1'b0;
        memWdata      = CH_CR;
        convStart     = 1'b0;
        tag           = TAG_ENC;

        // a queued set-output lands only when the motion engine is idle
        if (soPending_r && !bufBusy) begin
            outLevel_nxt  = soLevel_r;
            soPending_nxt = 1'b0;
        end

        case (kind_r)
            K_FMT:   tag = TAG_FMT;
            K_PAT:   tag = TAG_PAT;
            default: tag = TAG_ENC;
        endcase

        case (state_r)
            S_NAME: begin
                memWe    = 1'b1;
                memWdata = (idx_r == 4'h0) ? tag[15:8] : (idx_r == 4'h1) ? tag[7:0] : CH_EQ;
                idx_nxt  = idx_r + 4'h1;
                if (idx_r == NAME_LAST) begin
                    idx_nxt     = 4'h0;
                    started_nxt = 1'b0;
                    decMode_nxt = (kind_r == K_ENC) & fmtDec_r;
                    if ((kind_r == K_ENC) && fmtDec_r) begin
                        convStart = 1'b1;
                        state_nxt = S_CONV;
                    end else begin
                        state_nxt = S_BODY;
                    end
                end
            end
            S_CONV: begin
                if (convDone) begin
                    dig_nxt   = convBcd;
                    state_nxt = S_BODY;
                end
            end
            S_BODY: begin
                idx_nxt = idx_r + 4'h1;
                if (kind_r == K_FMT) begin
                    memWe     = 1'b1;
                    memWdata  = fmtDec_r ? CH_D : CH_H;
                    state_nxt = S_END;
                end else if (kind_r == K_PAT) begin
                    memWe    = 1'b1;
                    // only output 1 exists, upper seven positions always read zero
                    memWdata = ((idx_r == PAT_LAST) && outLevel_r) ? CH_ONE : CH_ZERO;
                    if (idx_r == PAT_LAST) begin
                        state_nxt = S_END;
                    end
                end else if (!decMode_r) begin
                    memWe     = 1'b1;
                    memWdata  = nibToChar(value_r[31:28]);
                    value_nxt = {value_r[27:0], 4'h0};
                    if (idx_r == HEX_LAST) begin
                        state_nxt = S_END;
                    end
                end else if (idx_r == 4'h0) begin
                    memWe    = neg_r;
                    memWdata = CH_MINUS;
                end else begin
                    // leading zeros dropped, the units digit always sent
                    memWe    = started_r | (dig_r[BCD_W-1 -: 4] != 4'h0) | (idx_r == DEC_LAST);
                    memWdata = nibToChar(dig_r[BCD_W-1 -: 4]);
                    started_nxt = memWe;
                    dig_nxt  = {dig_r[BCD_W-5:0], 4'h0};
                    if (idx_r == DEC_LAST) begin
                        state_nxt = S_END;
                    end
                end
            end
            S_END: begin
                memWe     = 1'b1;
                memWdata  = CH_CR;
                state_nxt = S_IDLE;
            end
            S_IDLE: begin
            end
            default: state_nxt = S_IDLE;
        endcase

        if (memWe) begin
            wrPtr_nxt = wrPtr_r + {{(MEM_AW-1){1'b0}}, 1'b1};
        end
        if (rdPop) begin
            rdPtr_nxt = rdPtr_r + {{(MEM_AW-1){1'b0}}, 1'b1};
        end
        cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, memWe} - {{(CNT_W-1){1'b0}}, rdPop};

        // commands are taken on the access edge of a write to the command word
        if (wrCmd) begin
            case (cmd.op)
                OP_FMT: begin
                    if (cmd.hasParam && cmd.param == CH_H) begin
                        fmtDec_nxt = 1'b0;
                    end else if (cmd.hasParam && cmd.param == CH_D) begin
                        fmtDec_nxt = 1'b1;
                    end else if (cmd.hasParam) begin
                        errSet = 1'b1;
                    end
                end
                OP_HIGH: begin
                    if (cmd.hasParam && cmd.param == OUT_NUM) begin
                        outLevel_nxt = LVL_OPEN;
                    end else begin
                        errSet = 1'b1;
                    end
                end
                OP_LOW: begin
                    if (cmd.hasParam && cmd.param == OUT_NUM) begin
                        outLevel_nxt = ~LVL_OPEN;
                    end else begin
                        errSet = 1'b1;
                    end
                end
                OP_PATTERN: begin
                    if (cmd.hasParam && cmd.param <= PAT_MAX) begin
                        outLevel_nxt = cmd.param[0];
                    end else if (cmd.hasParam) begin
                        errSet = 1'b1;
                    end
                end
                OP_BUFSET: begin
                    if (cmd.hasParam && (cmd.param == CH_H || cmd.param == CH_L)) begin
                        soPending_nxt = 1'b1;
                        soLevel_nxt   = (cmd.param == CH_H);
                    end else begin
                        errSet = 1'b1;
                    end
                end
                OP_ENC: begin
                end
                default: errSet = 1'b1;
            endcase

            // readouts issued while idle start a fresh reply (otherwise an error); the previous unread one is discarded
            if (cmd.op == OP_ENC || (!cmd.hasParam && (cmd.op == OP_FMT ||
                                     cmd.op == OP_PATTERN))) begin
                if (state_r != S_IDLE) begin
                    errSet = 1'b1;
                end else begin
                    state_nxt = S_NAME;
                    idx_nxt   = 4'h0;
                    kind_nxt  = (cmd.op == OP_ENC) ? K_ENC :
                                (cmd.op == OP_FMT) ? K_FMT : K_PAT;
                    value_nxt = encCount;
                    neg_nxt   = encCount[31];
                    wrPtr_nxt = '0;
                    rdPtr_nxt = '0;
                    cnt_nxt   = '0;
                end
            end
        end

        // a new error wins over a clear in the same cycle
        err_nxt = (err_r & ~errClr) | errSet;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r     <= S_IDLE;
            kind_r      <= K_ENC;
            idx_r       <= 4'h0;
            value_r     <= 32'h0;
            dig_r       <= '0;
            neg_r       <= 1'b0;
            decMode_r   <= 1'b0;
            started_r   <= 1'b0;
            fmtDec_r    <= FMT_HEX;
            outLevel_r  <= LVL_OPEN;
            soPending_r <= 1'b0;
            soLevel_r   <= LVL_OPEN;
            err_r       <= 1'b0;
            wrPtr_r     <= '0;
            rdPtr_r     <= '0;
            cnt_r       <= '0;
            prdata_r    <= 32'h0;
        end else begin
            state_r     <= state_nxt;
            kind_r      <= kind_nxt;
            idx_r       <= idx_nxt;
            value_r     <= value_nxt;
            dig_r       <= dig_nxt;
            neg_r       <= neg_nxt;
            decMode_r   <= decMode_nxt;
            started_r   <= started_nxt;
            fmtDec_r    <= fmtDec_nxt;
            outLevel_r  <= outLevel_nxt;
            soPending_r <= soPending_nxt;
            soLevel_r   <= soLevel_nxt;
            err_r       <= err_nxt;
            wrPtr_r     <= wrPtr_nxt;
            rdPtr_r     <= rdPtr_nxt;
            cnt_r       <= cnt_nxt;
            prdata_r    <= prdata_nxt;
        end
    end
endmodule

// [tb/iqoh_handler_monitor.sv]
`timescale 1ns/1ps
module iqoh_handler_monitor
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        bufBusy,
    input wire logic        outLevel
);
    import iqoh_pkg::*;
    iqoh_cmd_t c;
    logic      cmdWr;
    logic      mapped;
    assign c = pwdata[CMD_W-1:0];
    assign cmdWr = psel && penable && pwrite && paddr == OFS_CMD;
    assign mapped = paddr inside {OFS_CMD, OFS_STATUS, OFS_REPLY, OFS_ERRCLR};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ready_high_a: assert property (pready && (penable || !pslverr)) else $error("bad response");
    slverr_map_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong");
    high_now_a: assert property (cmdWr && c.op == OP_HIGH && c.hasParam && c.param == OUT_NUM
        |=> outLevel) else $error("output not opened");
    low_now_a: assert property (cmdWr && c.op == OP_LOW && c.hasParam && c.param == OUT_NUM
        |=> !outLevel) else $error("output not closed");
    pattern_set_a: assert property (cmdWr && c.op == OP_PATTERN && c.hasParam
        && c.param <= PAT_MAX |=> outLevel == $past(pwdata[16])) else $error("pattern");
    // a buffered set must wait while motion runs, so only an immediate command may move it
    buf_hold_a: assert property (bufBusy && !cmdWr |=> $stable(outLevel))
        else $error("output moved during motion");
    bad_output_a: assert property (cmdWr && c.op inside {OP_HIGH, OP_LOW} && bufBusy
        && c.param != OUT_NUM |=> $stable(outLevel)) else $error("bad output number");
    status_out_a: assert property (psel && penable && !pwrite && paddr == OFS_STATUS
        && $stable(outLevel) |-> prdata[ST_OUT_BIT] == outLevel) else $error("status out");
    cover property (cmdWr && c.op == OP_ENC);
    cover property (cmdWr && c.op == OP_BUFSET && bufBusy);
    cover property (cmdWr && c.op == OP_PATTERN && c.hasParam);
endmodule

bind iqoh_handler iqoh_handler_monitor mon (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bufBusy(bufBusy), .outLevel(outLevel));

// [tb/iqoh_host.sv]
`timescale 1ns/1ps
module iqoh_host
(
    input  wire logic        core_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready
);
    import iqoh_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // no release here: a following call starts its setup at once, back to back
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
    endtask
    // released lines flip so a stale value is never mistaken for a live one
    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
        @(posedge core_clk);
    endtask
endmodule

// [tb/iqoh_handler_tb.sv]
`timescale 1ns/1ps
module iqoh_handler_tb;
    import iqoh_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        bufBusy = 1'b0;
    logic [31:0] encCount = 32'h0;
    logic        psel, penable, pwrite, pready, pslverr, outLevel;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, got;
    logic [31:0] expQ[$], mskQ[$];
    int          num_errors = 0;
    int          n_checks = 0;
    int          seed = 32'h07E63C2D;
    event        resEv;
    always #2 core_clk = ~core_clk;
    iqoh_handler dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .encCount(encCount), .bufBusy(bufBusy), .outLevel(outLevel));
    iqoh_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        expQ.push_back(e & m);
        mskQ.push_back(m);
        host.xfer(1'b0, a, 32'h0, d);
        got = d;
        ->resEv;
    endtask
    always @(resEv) begin
        n_checks++;
        if ((got & mskQ[0]) !== expQ[0]) begin
            num_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, expQ[0], got & mskQ[0]);
        end
        void'(expQ.pop_front());
        void'(mskQ.pop_front());
    end
    task automatic cmd(input logic [2:0] op, input logic hp, input logic [7:0] p);
        iqoh_cmd_t   c;
        logic [31:0] d;
        c = '0;
        c.op = op;
        c.hasParam = hp;
        c.param = p;
        host.xfer(1'b1, OFS_CMD, {8'h00, c}, d);
    endtask
    // busy already reads high in the first status poll after the command; the loop also waits for a nonzero count
    task automatic reply(input string s);
        logic [31:0] d;
        repeat (100) begin
            host.xfer(1'b0, OFS_STATUS, 32'h0, d);
            if (d[ST_BUSY_BIT] === 1'b0 && d[ST_CNT_LSB+:5] !== 5'h0) break;
        end
        for (int i = 0; i < s.len(); i++)
            rdChk(OFS_REPLY, {23'h0, 1'b1, s[i]}, 32'h1FF);
        rdChk(OFS_REPLY, {23'h0, 1'b1, CH_CR}, 32'h1FF);
        rdChk(OFS_REPLY, 32'h0, 32'h1FF);
    endtask
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
    initial begin
        logic [31:0] v;
        logic [31:0] d;
        string       s;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rdChk(OFS_STATUS, 32'h08, 32'h1F1F);
        cmd(OP_FMT, 1'b0, 8'h00);
        reply("IF=H");
        $display("test defaults done");
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 3; k++) begin
                v = (k == 0) ? 32'h2710 : (k == 1) ? 32'hFFFFD8F0 : $random(seed);
                encCount <= v;
                cmd(OP_ENC, 1'b0, 8'h00);
                s = f ? $sformatf("%0d", $signed(v)) : $sformatf("%08h", v);
                reply($sformatf("%s=%s", TAG_ENC, s.toupper()));
            end
            cmd(OP_FMT, 1'b1, CH_D);
        end
        cmd(OP_FMT, 1'b0, 8'h00);
        reply("IF=D");
        $display("test encoder done");
        bufBusy <= 1'b1;
        cmd(OP_BUFSET, 1'b1, CH_L);
        cmd(OP_LOW, 1'b1, OUT_NUM);
        rdChk(OFS_STATUS, 32'h14, 32'h1F1F);
        cmd(OP_HIGH, 1'b1, OUT_NUM);
        rdChk(OFS_STATUS, 32'h1C, 32'h1F1F);
        cmd(OP_HIGH, 1'b1, 8'h02);
        rdChk(OFS_STATUS, 32'h1E, 32'h1F1F);
        bufBusy <= 1'b0;
        host.idle();
        rdChk(OFS_STATUS, 32'h06, 32'h1F1F);
        host.xfer(1'b1, OFS_ERRCLR, 32'h1, d);
        host.xfer(1'b0, 8'h10, 32'h0, d);
        rdChk(OFS_STATUS, 32'h04, 32'h1F1F);
        $display("test outputs done");
        for (int p = 1; p >= 0; p--) begin
            cmd(OP_PATTERN, 1'b1, 8'(p));
            cmd(OP_PATTERN, 1'b0, 8'h00);
            reply(p ? "IO=00000001" : "IO=00000000");
        end
        cmd(OP_PATTERN, 1'b1, 8'h02);
        rdChk(OFS_STATUS, 32'h06, 32'h1F1F);
        cmd(OP_BUFSET, 1'b1, CH_H);
        $display("test pattern done");
        host.idle();
        rdChk(OFS_STATUS, 32'h0E, 32'h1F1F);
        host.idle();
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rdChk(OFS_STATUS, 32'h08, 32'h1F1F);
        host.idle();
        $display("test second reset done");
        end_of_test();
    end
endmodule
